// File: hw/flash_ctl_defs.vh
// Purpose: Constants for the flash write and erase sequencer controller.
// Assumes: 20 MHz clock, APB register access with 32-bit data.
// Notes: All offsets are byte addresses of aligned words.
`ifndef FLASH_CTL_DEFS_VH
`define FLASH_CTL_DEFS_VH

// Register byte offsets.
`define REG_CMD_OFS 8'h00
`define REG_ADDR_OFS 8'h04
`define REG_WDATA_OFS 8'h08
`define REG_STATUS_OFS 8'h0C
`define REG_RDATA_OFS 8'h10
`define REG_CTRL_OFS 8'h14

// Operation codes written to the command register.
`define OP_READ_ARRAY 3'h0
`define OP_BYTE_WRITE 3'h1
`define OP_ERASE 3'h2
`define OP_READ_STATUS 3'h3
`define OP_CLEAR_STATUS 3'h4
`define OP_SUSPEND 3'h5
`define OP_RESUME 3'h6

// Device command codes.
`define CODE_WRITE_SETUP 8'h40
`define CODE_WRITE_SETUP_ALT 8'h10
`define CODE_ERASE_SETUP 8'h20
`define CODE_CONFIRM 8'hD0
`define CODE_SUSPEND 8'hB0
`define CODE_READ_STATUS 8'h70
`define CODE_CLEAR_STATUS 8'h50
`define CODE_READ_ARRAY 8'hFF

// Status byte field positions and the mask that keeps the used high bits.
`define SR_READY_BIT 7
`define SR_SUPPLY_LOW_BIT 3
`define SR_USED_MASK 8'hF8

// Controller status register field positions.
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_REFUSED_BIT 2
`define ST_RB_PIN_BIT 3
`define ST_SR_LSB 8

// Reset values.
`define CTRL_RESET 1'h0
`define ADDR_RESET 20'h00000
`define BYTE_RESET 8'h00

// Pin timing: strobe low time in ns, and cycles derived from the clock rate.
`define CLK_MHZ 20
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: hw/flash_bus_cycle.v
// Purpose: Runs one asynchronous flash bus cycle, a write or a read.
// Assumes: Pin inputs are synchronous to clk_i.
// Notes: Chip select is released after every cycle so status is relatched.
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defs.vh"

module flash_bus_cycle (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Request side.
  input wire start_i,
  input wire write_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg done_o,
  // Flash pins.
  output reg chip_select_n_o,
  output reg output_enable_n_o,
  output reg write_strobe_n_o,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output reg data_oe_o
);

  localparam [2:0] PH_IDLE = 3'h0;
  localparam [2:0] PH_SETUP = 3'h1;
  localparam [2:0] PH_STROBE = 3'h2;
  localparam [2:0] PH_HOLD = 3'h3;
  localparam [2:0] PH_RECOV = 3'h4;
  // Strobe count is derived as an integer and cut to the counter width on purpose.
  localparam integer STROBE_INT = (`STROBE_CYC) - 1;
  localparam [3:0] STROBE_LAST = STROBE_INT[3:0];

  reg [2:0] ph_r;
  reg [3:0] cnt_r;
  reg wr_r;

  // Phase sequencer: select, strobe, release strobe, deselect, recover.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ph_r <= PH_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      rdata_o <= `BYTE_RESET;
      done_o <= 1'b0;
      chip_select_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      data_o <= `BYTE_RESET;
      data_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (ph_r)
        PH_IDLE: begin
          if (start_i) begin
            wr_r <= write_i;
            data_o <= wdata_i;
            data_oe_o <= write_i;
            chip_select_n_o <= 1'b0;
            ph_r <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          write_strobe_n_o <= ~wr_r;
          output_enable_n_o <= wr_r;
          cnt_r <= STROBE_LAST;
          ph_r <= PH_STROBE;
        end
        PH_STROBE: begin
          if (cnt_r == 4'h0) begin
            write_strobe_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            if (!wr_r) begin
              rdata_o <= data_i;
            end
            ph_r <= PH_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        PH_HOLD: begin
          // deselect so the next read relatches.
          chip_select_n_o <= 1'b1;
          data_oe_o <= 1'b0;
          ph_r <= PH_RECOV;
        end
        PH_RECOV: begin
          done_o <= 1'b1;
          ph_r <= PH_IDLE;
        end
        default: begin
          ph_r <= PH_IDLE;
        end
      endcase
    end
  end

endmodule // flash_bus_cycle

`default_nettype wire

// File: hw/flash_write_erase_sequencer.v
// Purpose: Host controller that drives a byte-wide flash through its pins.
// Assumes: APB slave with zero wait states; pin inputs synchronous to clk_i.
// Notes: Software writes an operation code; the controller runs the
// command cycles, polls status and reports the result.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defs.vh"

module flash_write_erase_sequencer (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // APB slave.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Flash pins.
  output wire [19:0] flash_addr_o,
  output wire chip_select_n_o,
  output wire output_enable_n_o,
  output wire write_strobe_n_o,
  output wire power_down_reset_n_o,
  input wire ready_busy_n_i,
  input wire [7:0] flash_data_i,
  output wire [7:0] flash_data_o,
  output wire flash_data_oe_o
);

  localparam [1:0] RD_NONE = 2'h0;
  localparam [1:0] RD_ONCE = 2'h1;
  localparam [1:0] RD_POLL = 2'h2;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_FIRST = 2'h1;
  localparam [1:0] S_SECOND = 2'h2;
  localparam [1:0] S_READ = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [19:0] addr_r;
  reg [7:0] wdata_r;
  reg [7:0] rdata_r;
  reg [7:0] sr_r;
  reg ctrl_pd_r;
  reg done_r;
  reg refused_r;
  reg [7:0] code1_r;
  reg [7:0] code2_r;
  reg second_r;
  reg [1:0] rd_mode_r;
  reg array_rd_r;
  reg clear_op_r;
  reg cyc_start;
  reg cyc_write;
  reg [7:0] cyc_wdata;
  reg [7:0] code1_nxt;
  reg [7:0] code2_nxt;
  reg second_nxt;
  reg [1:0] rd_mode_nxt;
  reg [31:0] prdata_nxt;
  reg finish;
  wire [7:0] cyc_rdata;
  wire cyc_done;
  wire cs_n;
  wire oe_n;
  wire we_n;
  wire [7:0] dout;
  wire doe;
  wire wr_en;
  wire rd_en;
  wire cmd_wr;
  wire busy;
  wire mapped;
  wire start_ok;
  wire [2:0] op;

  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;
  assign mapped = (paddr_i == `REG_CMD_OFS) | (paddr_i == `REG_ADDR_OFS) |
                  (paddr_i == `REG_WDATA_OFS) | (paddr_i == `REG_STATUS_OFS) |
                  (paddr_i == `REG_RDATA_OFS) | (paddr_i == `REG_CTRL_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign cmd_wr = wr_en & (paddr_i == `REG_CMD_OFS);
  assign busy = (state_r != S_IDLE);
  assign op = pwdata_i[2:0];
  // refuse write or erase while supply low flag stands.
  assign start_ok = ~(sr_r[`SR_SUPPLY_LOW_BIT] &
                      ((op == `OP_BYTE_WRITE) | (op == `OP_ERASE)));

  // power-down held from the control bit; cycles idle meanwhile.
  assign power_down_reset_n_o = ~ctrl_pd_r;
  // same block address for setup and confirm cycles.
  assign flash_addr_o = addr_r;
  assign chip_select_n_o = cs_n;
  assign output_enable_n_o = oe_n;
  assign write_strobe_n_o = we_n;
  assign flash_data_o = dout;
  assign flash_data_oe_o = doe;
  assign prdata_o = rd_en ? prdata_nxt : 32'h00000000;

  // Command plan per operation code.
  always @* begin
    code1_nxt = `CODE_READ_ARRAY;
    code2_nxt = `BYTE_RESET;
    second_nxt = 1'b0;
    rd_mode_nxt = RD_NONE;
    case (op)
      `OP_BYTE_WRITE: begin
        // setup code then the data byte, then poll.
        code1_nxt = `CODE_WRITE_SETUP;
        code2_nxt = wdata_r;
        second_nxt = 1'b1;
        rd_mode_nxt = RD_POLL;
      end
      `OP_ERASE: begin
        code1_nxt = `CODE_ERASE_SETUP;
        code2_nxt = `CODE_CONFIRM;
        second_nxt = 1'b1;
        rd_mode_nxt = RD_POLL;
      end
      `OP_READ_STATUS: begin
        code1_nxt = `CODE_READ_STATUS;
        rd_mode_nxt = RD_ONCE;
      end
      `OP_CLEAR_STATUS: begin
        code1_nxt = `CODE_CLEAR_STATUS;
      end
      `OP_SUSPEND: begin
        code1_nxt = `CODE_SUSPEND;
        rd_mode_nxt = RD_POLL;
      end
      `OP_RESUME: begin
        code1_nxt = `CODE_CONFIRM;
        rd_mode_nxt = RD_POLL;
      end
      default: begin
        // array read command precedes every array read.
        code1_nxt = `CODE_READ_ARRAY;
        rd_mode_nxt = RD_ONCE;
      end
    endcase
  end

  // Sequencer: next state and cycle requests.
  always @* begin
    state_nxt = state_r;
    cyc_start = 1'b0;
    cyc_write = 1'b1;
    cyc_wdata = code1_r;
    finish = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (cmd_wr & start_ok & ~ctrl_pd_r) begin
          state_nxt = S_FIRST;
          cyc_start = 1'b1;
          cyc_wdata = code1_nxt;
        end
      end
      S_FIRST: begin
        if (cyc_done) begin
          if (second_r) begin
            // confirm or data cycle completes the pair.
            state_nxt = S_SECOND;
            cyc_start = 1'b1;
            cyc_wdata = code2_r;
          end else if (rd_mode_r != RD_NONE) begin
            state_nxt = S_READ;
            cyc_start = 1'b1;
            cyc_write = 1'b0;
          end else begin
            finish = 1'b1;
          end
        end
      end
      S_SECOND: begin
        if (cyc_done) begin
          state_nxt = S_READ;
          cyc_start = 1'b1;
          cyc_write = 1'b0;
        end
      end
      S_READ: begin
        if (cyc_done) begin
          // repeat status reads until ready bit is set.
          if ((rd_mode_r == RD_POLL) & ~cyc_rdata[`SR_READY_BIT]) begin
            cyc_start = 1'b1;
            cyc_write = 1'b0;
          end else begin
            finish = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    if (finish) begin
      state_nxt = S_IDLE;
    end
  end

  // Register read multiplexer.
  always @* begin
    prdata_nxt = 32'h00000000;
    case (paddr_i)
      `REG_ADDR_OFS: prdata_nxt = {12'h000, addr_r};
      `REG_WDATA_OFS: prdata_nxt = {24'h000000, wdata_r};
      `REG_STATUS_OFS: begin
        prdata_nxt[`ST_BUSY_BIT] = busy;
        prdata_nxt[`ST_DONE_BIT] = done_r;
        prdata_nxt[`ST_REFUSED_BIT] = refused_r;
        prdata_nxt[`ST_RB_PIN_BIT] = ready_busy_n_i;
        prdata_nxt[`ST_SR_LSB + 7:`ST_SR_LSB] = sr_r;
      end
      `REG_RDATA_OFS: prdata_nxt = {24'h000000, rdata_r};
      `REG_CTRL_OFS: prdata_nxt = {31'h00000000, ctrl_pd_r};
      default: prdata_nxt = 32'h00000000;
    endcase
  end

  // Registers, plan latches and result capture.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      addr_r <= `ADDR_RESET;
      wdata_r <= `BYTE_RESET;
      rdata_r <= `BYTE_RESET;
      sr_r <= `BYTE_RESET;
      ctrl_pd_r <= `CTRL_RESET;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      code1_r <= `CODE_READ_ARRAY;
      code2_r <= `BYTE_RESET;
      second_r <= 1'b0;
      rd_mode_r <= RD_NONE;
      array_rd_r <= 1'b0;
      clear_op_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (wr_en & ~busy & (paddr_i == `REG_ADDR_OFS)) begin
        addr_r <= pwdata_i[19:0];
      end
      if (wr_en & ~busy & (paddr_i == `REG_WDATA_OFS)) begin
        wdata_r <= pwdata_i[7:0];
      end
      if (wr_en & ~busy & (paddr_i == `REG_CTRL_OFS)) begin
        ctrl_pd_r <= pwdata_i[0];
      end
      if ((state_r == S_IDLE) & cmd_wr & start_ok & ~ctrl_pd_r) begin
        code1_r <= code1_nxt;
        code2_r <= code2_nxt;
        second_r <= second_nxt;
        rd_mode_r <= rd_mode_nxt;
        array_rd_r <= (op == `OP_READ_ARRAY) | (op == 3'h7);
        clear_op_r <= (op == `OP_CLEAR_STATUS);
      end
      if ((state_r == S_READ) & cyc_done) begin
        if (array_rd_r) begin
          rdata_r <= cyc_rdata;
        end else begin
          sr_r <= cyc_rdata & `SR_USED_MASK;
        end
      end else if (finish & clear_op_r) begin
        sr_r <= `BYTE_RESET;
      end
      // Sticky flags: a new event wins over a software clear.
      done_r <= finish |
                (done_r & ~(wr_en & (paddr_i == `REG_STATUS_OFS) &
                            pwdata_i[`ST_DONE_BIT]));
      refused_r <= ((state_r == S_IDLE) & cmd_wr & (~start_ok | ctrl_pd_r)) |
                   (refused_r & ~(wr_en & (paddr_i == `REG_STATUS_OFS) &
                                  pwdata_i[`ST_REFUSED_BIT]));
    end
  end

  // One flash bus cycle at a time.
  flash_bus_cycle u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cyc_start),
    .write_i(cyc_write),
    .wdata_i(cyc_wdata),
    .rdata_o(cyc_rdata),
    .done_o(cyc_done),
    .chip_select_n_o(cs_n),
    .output_enable_n_o(oe_n),
    .write_strobe_n_o(we_n),
    .data_i(flash_data_i),
    .data_o(dout),
    .data_oe_o(doe)
  );

endmodule // flash_write_erase_sequencer

`default_nettype wire

// File: verif/flash_seq_properties.sv
// Purpose: Concurrent checks on the sequencer's APB and flash pins.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module after the module body.
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defs.vh"
module flash_seq_properties (
  // Clock, reset and APB.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Flash pins.
  input wire logic [19:0] flash_addr_o,
  input wire logic chip_select_n_o,
  input wire logic output_enable_n_o,
  input wire logic write_strobe_n_o,
  input wire logic power_down_reset_n_o,
  input wire logic [7:0] flash_data_o,
  input wire logic flash_data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  logic mapped;
  logic pd_req;
  // Access phase, register decode and a power-down request.
  assign acc = psel_i && penable_i;
  assign mapped = paddr_i inside {`REG_CMD_OFS, `REG_ADDR_OFS, `REG_WDATA_OFS,
    `REG_STATUS_OFS, `REG_RDATA_OFS, `REG_CTRL_OFS};
  assign pd_req = acc && pwrite_i && paddr_i == `REG_CTRL_OFS && pwdata_i[0];
  zero_wait_a: assert property (acc |-> pready_o) else $error("pready low in access");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not flagged");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr_o) else $error("bad pslverr");
  idle_rdata_a: assert property (!(acc && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("prdata not zero");
  strobe_sel_a: assert property (
    !write_strobe_n_o |-> !chip_select_n_o && flash_data_oe_o && $stable(flash_data_o)
    && $stable(flash_addr_o)) else $error("write strobe without stable data");
  strobe_width_a: assert property ($fell(write_strobe_n_o) |->
    !write_strobe_n_o [*2] ##[1:2] write_strobe_n_o) else $error("strobe width");
  read_sel_a: assert property (!output_enable_n_o |->
    write_strobe_n_o && !flash_data_oe_o && !chip_select_n_o) else $error("read pins");
  select_gap_a: assert property ($rose(chip_select_n_o) |=> chip_select_n_o)
    else $error("select gap short");
  pd_cause_a: assert property ($fell(power_down_reset_n_o) |->
    $past(pd_req) || $past(pd_req, 2)) else $error("power-down without request");
  pd_quiet_a: assert property (!power_down_reset_n_o |->
    write_strobe_n_o && output_enable_n_o) else $error("strobe in power-down");
endmodule // flash_seq_properties
bind flash_write_erase_sequencer flash_seq_properties u_props (.clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .flash_addr_o, .chip_select_n_o, .output_enable_n_o, .write_strobe_n_o,
  .power_down_reset_n_o, .flash_data_o, .flash_data_oe_o);
`default_nettype wire

// File: verif/flash_dev_model.sv
// Purpose: Behavioural byte-wide flash device on the sequencer's pins.
// Assumes: Pins change on clk_i edges; 16 bytes stand for one block.
// Notes: delay_i sets busy time so the bench can answer fast or slow.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model (
  // Clock and test controls.
  input wire logic clk_i,
  input wire logic [15:0] delay_i,
  input wire logic supply_low_i,
  input wire logic prog_fail_i,
  // Device pins.
  input wire logic [19:0] addr_i,
  input wire logic chip_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic write_strobe_n_i,
  input wire logic power_down_reset_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic ready_busy_n_o
);
  logic [7:0] mem [16];
  logic [7:0] stat = 8'h80;
  logic [1:0] pend = 2'h0;
  logic show = 1'b0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  int cnt = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  initial data_o = 8'h00;
  // pin always driven, high in power-down
  assign ready_busy_n_o = !power_down_reset_n_i || stat[7];
  // clocked model; erase time shortened to delay_i twice over.
  always @(posedge clk_i) begin
    we_q <= write_strobe_n_i;
    oe_q <= output_enable_n_i;
    if (!power_down_reset_n_i) begin
      stat <= 8'h80;
      pend <= 2'h0;
      show <= 1'b0;
      cnt <= 0;
    end else begin
      // busy until the count runs out
      if (cnt == 1) stat[7] <= 1'b1;
      if (cnt > 0) cnt <= cnt - 1;
      // command taken at strobe rise with select low
      if (write_strobe_n_i && !we_q && !chip_select_n_i) begin
        pend <= 2'h0;
        show <= 1'b1;
        if (pend == 2'h1) begin
          if (supply_low_i || stat[3]) stat[3] <= 1'b1;
          else if (prog_fail_i) stat[4] <= 1'b1;
          else begin
            mem[addr_i[3:0]] <= mem[addr_i[3:0]] & data_i;
            stat[7] <= 1'b0;
            cnt <= delay_i;
          end
        // erase only after its confirm code
        end else if (pend == 2'h2) begin
          if (data_i != 8'hD0) stat[5:4] <= 2'b11;
          else if (supply_low_i || stat[3]) stat[3] <= 1'b1;
          else begin
            foreach (mem[i]) mem[i] <= 8'hFF;
            stat[7] <= 1'b0;
            cnt <= 2 * delay_i;
          end
        end else begin
          case (data_i)
            8'h40, 8'h10: pend <= 2'h1;
            8'h20: pend <= 2'h2;
            8'h50: stat[5:3] <= 3'h0;
            8'hFF: show <= 1'b0;
            default: ;
          endcase
        end
      end
    end
    // status latched as enable falls; lines toggle when released
    if (!chip_select_n_i && !output_enable_n_i)
      data_o <= !show ? mem[addr_i[3:0]] : oe_q ? stat & 8'hF8 : data_o;
    else
      data_o <= ~data_o;
  end
endmodule // flash_dev_model
`default_nettype wire

// File: verif/testbench.sv
// Purpose: Self-checking bench for the flash write and erase sequencer.
// Assumes: 20 MHz clock; the flash model answers on the pins.
// Notes: Reads queue expected values; a monitor compares on completion.
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defs.vh"
module testbench;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] LOW = 32'h0000000F;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, chip_select_n_o, output_enable_n_o, write_strobe_n_o;
  wire power_down_reset_n_o, ready_busy_n_i, flash_data_oe_o;
  wire [19:0] flash_addr_o;
  wire [7:0] flash_data_i, flash_data_o;
  logic [15:0] delay = 16'h0004;
  logic supply_low = 1'b0;
  logic prog_fail = 1'b0;
  logic [63:0] exp_q [$];
  logic [63:0] e;
  logic [7:0] mirror [2];
  logic [7:0] d8;
  logic [31:0] q;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  flash_write_erase_sequencer uut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .flash_addr_o,
    .chip_select_n_o, .output_enable_n_o, .write_strobe_n_o, .power_down_reset_n_o,
    .ready_busy_n_i, .flash_data_i, .flash_data_o, .flash_data_oe_o);
  flash_dev_model dev (.clk_i(clk_i), .delay_i(delay), .supply_low_i(supply_low),
    .prog_fail_i(prog_fail), .addr_i(flash_addr_o), .chip_select_n_i(chip_select_n_o),
    .output_enable_n_i(output_enable_n_o), .write_strobe_n_i(write_strobe_n_o),
    .power_down_reset_n_i(power_down_reset_n_o), .data_i(flash_data_o),
    .data_o(flash_data_i), .ready_busy_n_o(ready_busy_n_i));
  // Clock at 50 ns period.
  initial forever #25 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: read %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; a read queues its expected value and mask.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= w ? d : 32'h0;
    if (!w) exp_q.push_back({m, d});
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Poll until idle, check status, then clear the sticky flags.
  task automatic finish_op(input logic [31:0] want, input logic [31:0] m);
    q = 32'h1;
    while (q[0] !== 1'b0) apb(1'b0, `REG_STATUS_OFS, 32'h0, 32'h0);
    apb(1'b0, `REG_STATUS_OFS, want, m);
    apb(1'b1, `REG_STATUS_OFS, 32'h6, 32'h0);
  endtask
  task automatic run_op(input logic [2:0] op, input logic [31:0] want,
      input logic [31:0] m);
    apb(1'b1, `REG_CMD_OFS, {29'h0, op}, 32'h0);
    finish_op(want, m);
  endtask
  // Compares completed reads with the oldest note, and cuts a hang short.
  always @(posedge clk_i) begin
    cyc++;
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[63:32] != 32'h0) check(prdata_o & e[63:32], e[31:0] & e[63:32]);
    end
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end
  // Main sequence.
  initial begin
    q = $urandom(9);
    mirror[0] = 8'hFF;
    mirror[1] = 8'hFF;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, `REG_STATUS_OFS, 32'h00000008, ALL);
    apb(1'b0, `REG_ADDR_OFS, 32'h0, ALL);
    apb(1'b0, `REG_CTRL_OFS, 32'h0, ALL);
    apb(1'b0, 8'h20, 32'h0, ALL);
    for (int i = 0; i < 4; i++) begin
      d8 = 8'($urandom());
      apb(1'b1, `REG_ADDR_OFS, 32'(i % 2), 32'h0);
      apb(1'b1, `REG_WDATA_OFS, {24'h0, d8}, 32'h0);
      run_op(3'h1, 32'h0000800A, ALL);
      mirror[i % 2] = mirror[i % 2] & d8;
      run_op(3'h0, 32'h0000000A, LOW);
      apb(1'b0, `REG_RDATA_OFS, {24'h0, mirror[i % 2]}, ALL);
    end
    delay <= 16'h012C;
    apb(1'b1, `REG_CMD_OFS, 32'h2, 32'h0);
    apb(1'b1, `REG_ADDR_OFS, 32'h9, 32'h0);
    repeat (20) @(posedge clk_i);
    apb(1'b0, `REG_ADDR_OFS, 32'h1, ALL);
    apb(1'b0, `REG_STATUS_OFS, 32'h1, 32'h9);
    finish_op(32'h0000800A, ALL);
    run_op(3'h0, 32'h0000000A, LOW);
    apb(1'b0, `REG_RDATA_OFS, 32'hFF, ALL);
    delay <= 16'h0002;
    supply_low <= 1'b1;
    run_op(3'h1, 32'h0000880A, ALL);
    supply_low <= 1'b0;
    run_op(3'h1, 32'h0000880C, ALL);
    run_op(3'h4, 32'h0000000A, ALL);
    run_op(3'h3, 32'h0000800A, ALL);
    prog_fail <= 1'b1;
    run_op(3'h1, 32'h0000900A, ALL);
    prog_fail <= 1'b0;
    run_op(3'h1, 32'h0000900A, ALL);
    apb(1'b1, `REG_CTRL_OFS, 32'h1, 32'h0);
    apb(1'b0, `REG_CTRL_OFS, 32'h1, ALL);
    run_op(3'h1, 32'h0000000C, LOW);
    apb(1'b1, `REG_CTRL_OFS, 32'h0, 32'h0);
    run_op(3'h3, 32'h0000800A, ALL);
    for (int k = 5; k < 7; k++) run_op(3'(k), 32'h0000000A, LOW);
    // Second reset in mid-run, then the spare read-array code at block offset zero.
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, `REG_STATUS_OFS, 32'h00000008, ALL);
    run_op(3'h7, 32'h0000000A, LOW);
    apb(1'b0, `REG_RDATA_OFS, 32'hFF, ALL);
    final_report();
  end
endmodule // testbench
`default_nettype wire
